/* design/seq_pkg.sv */
// shared constants and carrier types for the power sequencer
package seq_pkg;
	localparam int          NUM_RES        = 8;
	localparam int          TIMER_W        = 8;
	localparam int          CLK_REQ_W      = 4;
	localparam int          REQ_TIMER_N    = 2;
	localparam real         SEQ_CLK_KHZ    = 32.768;
	localparam real         SYS_CLK_KHZ    = 10000.0;
	// divider count for the sequencer tick, rounded to nearest
	localparam int          SEQ_DIV        = int'(SYS_CLK_KHZ / SEQ_CLK_KHZ);
	localparam int          DIV_W          = 9;
	localparam int          RES_CORE_BUCK  = 0;
	localparam int          RES_CORE_LDO   = 1;
	localparam int          RES_LN_LDO     = 2;
	// wishbone register byte addresses
	localparam logic [7:0]  ADR_MIN_MASK   = 8'h00;
	localparam logic [7:0]  ADR_ON_FLAG    = 8'h04;
	localparam logic [7:0]  ADR_IN_TRANS   = 8'h08;
	localparam logic [7:0]  ADR_PIN_STATUS = 8'h0C;
	localparam logic [7:0]  ADR_DELAY_BASE = 8'h40;
	localparam logic [7:0]  MIN_MASK_RST   = 8'h00;
	localparam logic [TIMER_W-1:0] DELAY_RST = 8'h04;
	localparam int          DLY_OFF_POS    = 8;

	typedef enum logic [3:0] {
		ST_DISABLED = 4'h1,
		ST_TURN_ON  = 4'h2,
		ST_ENABLED  = 4'h4,
		ST_TURN_OFF = 4'h8
	} res_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic wlan_power_on;
		logic bt_power_on;
		logic bt_core_reset_n;
		logic ext_buck_keep_on;
		logic ext_pwm_force;
		logic burst_request;
	} pins_t;

	typedef struct packed {
		logic regulators_en;
		logic core_buck_en;
		logic core_buck_pwm;
		logic wlan_reset_n;
		logic bt_reset_n;
		logic main_clock_en;
		logic outputs_en;
	} power_ctl_t;
endpackage : seq_pkg

/* design/power_sequencer.sv */
// resource power sequencer with wishbone registers and power-on pin control
// Overview of operation
// - timers count down each sequencer tick
// - four states per resource
// - timer zero at rest, loaded on switch
// - timer zero ends transition state
// - zero delay switches directly
// - required set is union of sources
// - clock requests map to resources
// - required set computed every tick
// - at zero clear transition, flip on
// - disable unrequested enabled resource without dependents
// - enable requested resource with dependencies enabled
// - wlan power on releases wlan reset
// - regulators enabled by either power on
// - both power ons low disables regulators
// - bt reset affects bt core and gates pwm force
// - keep-on request holds core buck on
// - pwm force with keep-on and a live radio overrides burst request
// - higher power mode wins conflicts
// - doze stops main clocks, tick runs
// - shutdown tristates outputs
// - power up retains no resource state or min mask, delays kept
module power_sequencer #(
	parameter int NUM_RES   = seq_pkg::NUM_RES,
	parameter int TIMER_W   = seq_pkg::TIMER_W,
	parameter int CLK_REQ_W = seq_pkg::CLK_REQ_W,
	parameter int REQ_TMR_N = seq_pkg::REQ_TIMER_N,
	// bit j of entry i: resource i depends on resource j
	parameter logic [NUM_RES-1:0] DEP_TABLE [NUM_RES] = '{default: '0},
	// bit j of entry k: clock request k needs resource j
	parameter logic [NUM_RES-1:0] CLK_MAP [CLK_REQ_W] = '{default: '1}
) (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	// wishbone slave
	input  wire seq_pkg::wb_req_t     wb_req_i,
	output seq_pkg::wb_rsp_t          wb_rsp_o,
	// request sources
	input  wire logic [CLK_REQ_W-1:0] clk_request_i,
	input  wire logic [REQ_TMR_N-1:0] req_timer_active_i,
	input  wire logic [NUM_RES-1:0]   req_timer_mask_i [REQ_TMR_N],
	// power pins
	input  wire seq_pkg::pins_t       pins_i,
	// outputs
	output logic [NUM_RES-1:0]        resource_en_o,
	output seq_pkg::power_ctl_t       power_ctl_o,
	output logic                      seq_tick_o
);
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [seq_pkg::DIV_W-1:0]         div;
		logic                              tick;
		logic [NUM_RES-1:0]                min_mask;
		logic [NUM_RES-1:0][TIMER_W-1:0]   on_dly;
		logic [NUM_RES-1:0][TIMER_W-1:0]   off_dly;
		logic [NUM_RES-1:0][TIMER_W-1:0]   timer;
		logic [NUM_RES-1:0]                on_flag;
		logic [NUM_RES-1:0]                in_trans;
		logic                              ack;
		logic [31:0]                       rdat;
		seq_pkg::power_ctl_t               ctl;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	logic [NUM_RES-1:0] required;
	logic [NUM_RES-1:0] on_after;
	logic [NUM_RES-1:0] trans_after;
	logic [NUM_RES-1:0] have_dependents;
	logic [NUM_RES-1:0] deps_ok;
	logic               any_power_on;
	logic               wb_hit;
	logic               wb_commit;
	logic               radio_live;

	////////////////////////////////////////////////////////////////////////////
	// request collection
	always_comb begin
		required = s_r.min_mask;
		for (int k = 0; k < CLK_REQ_W; k++) begin
			if (clk_request_i[k]) begin
				required = required | CLK_MAP[k];
			end
		end
		for (int t = 0; t < REQ_TMR_N; t++) begin
			if (req_timer_active_i[t]) begin
				required = required | req_timer_mask_i[t];
			end
		end
		if (pins_i.ext_buck_keep_on) begin
			required[seq_pkg::RES_CORE_BUCK] = 1'b1;
		end
		// pull in dependencies of required resources
		// without this a dependent would wait forever on an unrequested parent
		for (int p = 0; p < NUM_RES; p++) begin
			for (int i = 0; i < NUM_RES; i++) begin
				if (required[i]) begin
					required = required | DEP_TABLE[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// dependency evaluation against post-decrement state
	always_comb begin
		have_dependents = '0;
		deps_ok         = '1;
		for (int i = 0; i < NUM_RES; i++) begin
			for (int j = 0; j < NUM_RES; j++) begin
				if (DEP_TABLE[i][j]) begin
					if (on_after[i] || trans_after[i]) begin
						have_dependents[j] = 1'b1;
					end
					if (!(on_after[j] && !trans_after[j])) begin
						deps_ok[i] = 1'b0;
					end
				end
			end
		end
	end

	assign any_power_on = pins_i.wlan_power_on | pins_i.bt_power_on;
	assign wb_hit       = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;
	// the master holds a write until it samples ack, so it commits only then
	assign wb_commit    = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & s_r.ack;
	assign radio_live   = pins_i.wlan_power_on | (pins_i.bt_power_on & pins_i.bt_core_reset_n);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [7:0] idx;
		idx         = 8'h00;
		s_nxt       = s_r;
		s_nxt.tick  = 1'b0;
		s_nxt.ack   = 1'b0;
		on_after    = s_r.on_flag;
		trans_after = s_r.in_trans;
		if (s_r.div == seq_pkg::DIV_W'(seq_pkg::SEQ_DIV - 1)) begin
			s_nxt.div  = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.div = s_r.div + 1'b1;
		end
		if (s_r.tick) begin
			for (int i = 0; i < NUM_RES; i++) begin
				if (s_r.timer[i] != '0) begin
					s_nxt.timer[i] = s_r.timer[i] - 1'b1;
					if (s_r.timer[i] == TIMER_W'(1)) begin
						trans_after[i] = 1'b0;
						on_after[i]    = ~s_r.on_flag[i];
					end
				end
			end
			s_nxt.on_flag  = on_after;
			s_nxt.in_trans = trans_after;
			for (int i = 0; i < NUM_RES; i++) begin
				if (!trans_after[i]) begin
					if (on_after[i] && !required[i] && !have_dependents[i]) begin
						if (s_r.off_dly[i] == '0) begin
							s_nxt.on_flag[i] = 1'b0;
						end else begin
							s_nxt.timer[i]    = s_r.off_dly[i];
							s_nxt.in_trans[i] = 1'b1;
						end
					end else if (!on_after[i] && required[i] && deps_ok[i]) begin
						if (s_r.on_dly[i] == '0) begin
							s_nxt.on_flag[i] = 1'b1;
						end else begin
							s_nxt.timer[i]    = s_r.on_dly[i];
							s_nxt.in_trans[i] = 1'b1;
						end
					end
				end
			end
		end
		// register access, one wait state; a write commits at the edge its ack is taken
		if (wb_hit) begin
			s_nxt.ack  = 1'b1;
			s_nxt.rdat = 32'h0000_0000;
		end
		if (wb_req_i.adr >= seq_pkg::ADR_DELAY_BASE) begin
			idx = (wb_req_i.adr - seq_pkg::ADR_DELAY_BASE) >> 2;
		end
		if (wb_req_i.adr == seq_pkg::ADR_MIN_MASK) begin
			if (wb_hit) begin
				s_nxt.rdat[NUM_RES-1:0] = s_r.min_mask;
			end
			if (wb_commit && wb_req_i.sel[0]) begin
				s_nxt.min_mask = wb_req_i.dat[NUM_RES-1:0];
			end
		end else if (wb_hit && wb_req_i.adr == seq_pkg::ADR_ON_FLAG) begin
			s_nxt.rdat[NUM_RES-1:0] = s_r.on_flag;
		end else if (wb_hit && wb_req_i.adr == seq_pkg::ADR_IN_TRANS) begin
			s_nxt.rdat[NUM_RES-1:0] = s_r.in_trans;
		end else if (wb_hit && wb_req_i.adr == seq_pkg::ADR_PIN_STATUS) begin
			s_nxt.rdat[6:0] = s_r.ctl;
		end else if (wb_req_i.adr[1:0] == 2'h0 && idx < 8'(NUM_RES)
				&& wb_req_i.adr >= seq_pkg::ADR_DELAY_BASE) begin
			if (wb_hit) begin
				s_nxt.rdat[TIMER_W-1:0] = s_r.on_dly[idx];
				s_nxt.rdat[seq_pkg::DLY_OFF_POS +: TIMER_W] = s_r.off_dly[idx];
			end
			if (wb_commit && wb_req_i.sel[0]) begin
				s_nxt.on_dly[idx] = wb_req_i.dat[TIMER_W-1:0];
			end
			if (wb_commit && wb_req_i.sel[1]) begin
				s_nxt.off_dly[idx] = wb_req_i.dat[seq_pkg::DLY_OFF_POS +: TIMER_W];
			end
		end
		s_nxt.ctl.regulators_en = any_power_on;
		// wlan reset follows its power on
		s_nxt.ctl.wlan_reset_n  = pins_i.wlan_power_on;
		// bt reset touches bt core here and gates pwm force via radio_live
		s_nxt.ctl.bt_reset_n    = pins_i.bt_power_on & pins_i.bt_core_reset_n;
		s_nxt.ctl.core_buck_en  = any_power_on | pins_i.ext_buck_keep_on;
		s_nxt.ctl.core_buck_pwm = (radio_live & pins_i.ext_buck_keep_on
			& pins_i.ext_pwm_force) | ~pins_i.burst_request;
		// main clocks off with no clock request
		s_nxt.ctl.main_clock_en = any_power_on & (|clk_request_i);
		s_nxt.ctl.outputs_en    = any_power_on;
		if (!any_power_on) begin
			s_nxt.on_flag  = '0;
			s_nxt.in_trans = '0;
			s_nxt.timer    = '0;
			s_nxt.min_mask = NUM_RES'(seq_pkg::MIN_MASK_RST);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r          <= '0;
			s_r.min_mask <= NUM_RES'(seq_pkg::MIN_MASK_RST);
			s_r.on_dly   <= {NUM_RES{TIMER_W'(seq_pkg::DELAY_RST)}};
			s_r.off_dly  <= {NUM_RES{TIMER_W'(seq_pkg::DELAY_RST)}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_rsp_o.ack = s_r.ack;
	assign wb_rsp_o.dat = s_r.rdat;
	assign power_ctl_o  = s_r.ctl;
	assign seq_tick_o   = s_r.tick;

	for (genvar g = 0; g < NUM_RES; g++) begin : g_res
		seq_pkg::res_state_t st;
		always_comb begin
			unique case ({s_r.on_flag[g], s_r.in_trans[g]})
				2'b00: st = seq_pkg::ST_DISABLED;
				2'b01: st = seq_pkg::ST_TURN_ON;
				2'b10: st = seq_pkg::ST_ENABLED;
				2'b11: st = seq_pkg::ST_TURN_OFF;
			endcase
		end
		assign resource_en_o[g] = (st == seq_pkg::ST_ENABLED) | (st == seq_pkg::ST_TURN_OFF);

		property p_timer_rest;
			@(posedge clk_i) disable iff (!rst_b_i)
			!s_r.in_trans[g] |-> s_r.timer[g] == '0;
		endproperty
		a_timer_rest: assert property (p_timer_rest) else $error("timer nonzero at rest");

		property p_end;
			@(posedge clk_i) disable iff (!rst_b_i)
			// a zero-delay reversal in the same tick legally flips the flag back
			(s_r.tick && s_r.timer[g] == TIMER_W'(1) && any_power_on
				&& (s_r.on_flag[g] ? s_r.on_dly[g] != '0 : s_r.off_dly[g] != '0))
				|=> s_r.on_flag[g] != $past(s_r.on_flag[g]);
		endproperty
		a_end: assert property (p_end) else $error("transition did not complete");

		// count down by one per tick
		property p_dec;
			@(posedge clk_i) disable iff (!rst_b_i)
			(s_r.tick && s_r.timer[g] > TIMER_W'(1) && any_power_on)
				|=> s_r.timer[g] == $past(s_r.timer[g]) - 1'b1;
		endproperty
		a_dec: assert property (p_dec) else $error("timer did not decrement");

		property p_clr;
			@(posedge clk_i) disable iff (!rst_b_i)
			$fell(s_r.in_trans[g]) |-> s_r.timer[g] == '0;
		endproperty
		a_clr: assert property (p_clr) else $error("transition flag cleared early");

		property p_hold;
			@(posedge clk_i) disable iff (!rst_b_i)
			(!s_r.tick && s_r.in_trans[g] && any_power_on) |=> $stable(s_r.timer[g]);
		endproperty
		a_hold: assert property (p_hold) else $error("timer moved off tick");
	end

	property p_wlan;
		@(posedge clk_i) disable iff (!rst_b_i)
		pins_i.wlan_power_on |=> power_ctl_o.wlan_reset_n && power_ctl_o.regulators_en;
	endproperty
	a_wlan: assert property (p_wlan) else $error("wlan not released");

	property p_off;
		@(posedge clk_i) disable iff (!rst_b_i)
		(!pins_i.wlan_power_on && !pins_i.bt_power_on) |=> !power_ctl_o.regulators_en;
	endproperty
	a_off: assert property (p_off) else $error("regulators stayed on");

	property p_keep;
		@(posedge clk_i) disable iff (!rst_b_i)
		pins_i.ext_buck_keep_on |=> power_ctl_o.core_buck_en;
	endproperty
	a_keep: assert property (p_keep) else $error("core buck dropped");

	property p_pwm;
		@(posedge clk_i) disable iff (!rst_b_i)
		((pins_i.wlan_power_on || (pins_i.bt_power_on && pins_i.bt_core_reset_n))
			&& pins_i.ext_buck_keep_on && pins_i.ext_pwm_force)
			|=> power_ctl_o.core_buck_pwm;
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm not forced");

	property p_reg_on;
		@(posedge clk_i) disable iff (!rst_b_i)
		(pins_i.wlan_power_on || pins_i.bt_power_on) |=> power_ctl_o.regulators_en;
	endproperty
	a_reg_on: assert property (p_reg_on) else $error("regulators not enabled");

	// power down keeps no resource state
	property p_wipe;
		@(posedge clk_i) disable iff (!rst_b_i)
		(!pins_i.wlan_power_on && !pins_i.bt_power_on) |=> s_r.on_flag == '0 && s_r.in_trans == '0;
	endproperty
	a_wipe: assert property (p_wipe) else $error("state kept over power down");

	property p_tristate;
		@(posedge clk_i) disable iff (!rst_b_i)
		(!pins_i.wlan_power_on && !pins_i.bt_power_on) |=> !power_ctl_o.outputs_en;
	endproperty
	a_tristate: assert property (p_tristate) else $error("outputs driven in shutdown");

	// no clock request stops main clocks
	property p_doze;
		@(posedge clk_i) disable iff (!rst_b_i)
		(clk_request_i == '0) |=> !power_ctl_o.main_clock_en;
	endproperty
	a_doze: assert property (p_doze) else $error("main clocks run in doze");

	property p_tick;
		@(posedge clk_i) disable iff (!rst_b_i)
		seq_tick_o |=> !seq_tick_o [*2];
	endproperty
	a_tick: assert property (p_tick) else $error("tick too frequent");
endmodule : power_sequencer

/* tb/host_pins.sv */
// host model driving the power-on and reset pins
module host_pins (
	// clock
	input  wire logic           clk_i,
	// wanted levels
	input  wire seq_pkg::pins_t want_i,
	// pins
	output seq_pkg::pins_t      pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pins_o = '0;
	// reset pin driven
	// an unknown reset wish is never passed on as a floating level
	always @(posedge clk_i) begin
		pins_o <= '{wlan_power_on: want_i.wlan_power_on, bt_power_on: want_i.bt_power_on,
			bt_core_reset_n: (want_i.bt_core_reset_n !== 1'b0),
			ext_buck_keep_on: want_i.ext_buck_keep_on, ext_pwm_force: want_i.ext_pwm_force,
			burst_request: want_i.burst_request};
	end
endmodule : host_pins

/* tb/power_sequencer_test.sv */
// self-checking bench for the power sequencer
module power_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk_i;
	logic                rst_b_i;
	seq_pkg::wb_req_t    wb_req;
	seq_pkg::wb_rsp_t    wb_rsp;
	logic [3:0]          clk_req;
	logic [1:0]          tmr_act;
	logic [7:0]          tmr_mask [2];
	seq_pkg::pins_t      want;
	seq_pkg::pins_t      pins;
	logic [7:0]          res_en;
	seq_pkg::power_ctl_t pctl;
	logic                tick;
	int                  n_errors;
	int                  checked;
	logic [31:0]         rd;

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// resource 4 leans on resource 3; clock request 0 needs resource 4 only
	power_sequencer #(
		.DEP_TABLE('{4: 8'h08, default: 8'h00}),
		.CLK_MAP  ('{0: 8'h10, default: 8'h00})
	) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_req_i(wb_req),
		.wb_rsp_o(wb_rsp), .clk_request_i(clk_req), .req_timer_active_i(tmr_act),
		.req_timer_mask_i(tmr_mask), .pins_i(pins), .resource_en_o(res_en),
		.power_ctl_o(pctl), .seq_tick_o(tick));
	host_pins i_host (.clk_i(clk_i), .want_i(want), .pins_o(pins));

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	// ack is sampled at the edge, before that edge's updates land
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 40);
		rd = wb_rsp.dat;
		wb_req <= '0;
		if (n >= 40) begin
			n_errors++;
			give_verdict();
		end
	endtask : bus

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(rd, exp)
	endtask : rd_chk

	task automatic wait_tick(input int k);
		int n;
		repeat (k) begin
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (tick !== 1'b1 && n < 400);
			if (tick !== 1'b1) begin
				n_errors++;
				give_verdict();
			end
		end
		repeat (2) @(posedge clk_i);
	endtask : wait_tick

	// bits: burst wish, wlan on, bt on, bt reset_n, keep-on, pwm force
	task automatic set_pins(input logic [5:0] v);
		want <= '{wlan_power_on: v[4], bt_power_on: v[3], bt_core_reset_n: v[2],
			ext_buck_keep_on: v[1], ext_pwm_force: v[0], burst_request: v[5]};
		repeat (3) @(posedge clk_i);
	endtask : set_pins

	task automatic t_regs();
		rd_chk(seq_pkg::ADR_MIN_MASK, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			rd_chk(seq_pkg::ADR_DELAY_BASE + 8'(4 * i), 32'h0000_0404);
		end
		rd_chk(8'h80, 32'h0000_0000);
		bus(1'b1, seq_pkg::ADR_ON_FLAG, 32'h0000_00FF);
		rd_chk(seq_pkg::ADR_ON_FLAG, 32'h0000_0000);
	endtask : t_regs

	task automatic t_pins();
		logic [5:0] v;
		for (int i = 0; i < 64; i++) begin
			v = 6'(i);
			set_pins(v);
			`CHK(pctl.regulators_en, v[4] | v[3])
			`CHK(pctl.regulators_en, ~(~v[4] & ~v[3]))
			`CHK(pctl.wlan_reset_n, v[4])
			`CHK(pctl.bt_reset_n, v[3] & v[2])
			`CHK(pctl.outputs_en, v[4] | v[3])
			`CHK(pctl.main_clock_en, 1'b0)
			`CHK(pctl.core_buck_pwm, ((v[4] | (v[3] & v[2])) & v[1] & v[0]) | ~v[5])
			`CHK(pctl.core_buck_en, v[4] | v[3] | v[1])
		end
	endtask : t_pins

	// one resource through a timed enable sequence
	task automatic up(input int b, input int d);
		wait_tick(1);
		bus(1'b0, seq_pkg::ADR_IN_TRANS, 32'h0000_0000);
		`CHK(rd[b], 1'b1)
		bus(1'b0, seq_pkg::ADR_ON_FLAG, 32'h0000_0000);
		`CHK(rd[b], 1'b0)
		wait_tick(d - 1);
		bus(1'b0, seq_pkg::ADR_IN_TRANS, 32'h0000_0000);
		`CHK(rd[b], 1'b1)
		wait_tick(1);
		bus(1'b0, seq_pkg::ADR_IN_TRANS, 32'h0000_0000);
		`CHK(rd[b], 1'b0)
		bus(1'b0, seq_pkg::ADR_ON_FLAG, 32'h0000_0000);
		`CHK(rd[b], 1'b1)
		`CHK(res_en[b], 1'b1)
	endtask : up

	task automatic t_seq();
		set_pins(6'b110100);
		bus(1'b1, seq_pkg::ADR_DELAY_BASE + 8'h04, 32'h0000_0002);
		bus(1'b1, seq_pkg::ADR_MIN_MASK, 32'h0000_0002);
		up(1, 2);
		bus(1'b1, seq_pkg::ADR_MIN_MASK, 32'h0000_0000);
		wait_tick(1);
		rd_chk(seq_pkg::ADR_IN_TRANS, 32'h0000_0000);
		rd_chk(seq_pkg::ADR_ON_FLAG, 32'h0000_0000);
		`CHK(res_en[1], 1'b0)
		tmr_mask[0] <= 8'h04;
		tmr_act <= 2'b01;
		up(2, 4);
	endtask : t_seq

	// a clock request pulls in a chain of two resources, then lets it go
	task automatic t_deps();
		wait_tick(1);
		clk_req <= 4'h1;
		repeat (3) @(posedge clk_i);
		`CHK(pctl.main_clock_en, 1'b1)
		wait_tick(1);
		rd_chk(seq_pkg::ADR_IN_TRANS, 32'h0000_0008);
		wait_tick(4);
		rd_chk(seq_pkg::ADR_IN_TRANS, 32'h0000_0010);
		rd_chk(seq_pkg::ADR_ON_FLAG, 32'h0000_000C);
		wait_tick(4);
		rd_chk(seq_pkg::ADR_ON_FLAG, 32'h0000_001C);
		clk_req <= 4'h0;
		wait_tick(1);
		rd_chk(seq_pkg::ADR_IN_TRANS, 32'h0000_0010);
		wait_tick(4);
		rd_chk(seq_pkg::ADR_IN_TRANS, 32'h0000_0008);
		rd_chk(seq_pkg::ADR_ON_FLAG, 32'h0000_000C);
	endtask : t_deps

	// power down and up again forgets min mask and resource state
	task automatic t_wipe();
		tmr_act <= 2'b00;
		bus(1'b1, seq_pkg::ADR_MIN_MASK, 32'h0000_0020);
		rd_chk(seq_pkg::ADR_MIN_MASK, 32'h0000_0020);
		set_pins(6'b100000);
		set_pins(6'b110100);
		rd_chk(seq_pkg::ADR_MIN_MASK, 32'h0000_0000);
		rd_chk(seq_pkg::ADR_ON_FLAG, 32'h0000_0000);
		rd_chk(seq_pkg::ADR_IN_TRANS, 32'h0000_0000);
	endtask : t_wipe

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b_i = 1'b0;
		wb_req = '0;
		clk_req = 4'h0;
		tmr_act = 2'h0;
		tmr_mask = '{default: 8'h00};
		want = '0;
		n_errors = 0;
		checked = 0;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs();
		t_pins();
		t_seq();
		t_deps();
		t_wipe();
		give_verdict();
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk_i);
		n_errors++;
		give_verdict();
	end
endmodule : power_sequencer_test
